/* design/dcsm_defines.svh */
// Offsets, field positions, reset values for the channel status monitor
`ifndef DCSM_DEFINES_SVH
`define DCSM_DEFINES_SVH
`define DCSM_OFF_IRQ_SUMMARY   12'h024
`define DCSM_OFF_BUSY_VECTOR   12'h028
`define DCSM_OFF_PEND_VECTOR   12'h02c
`define DCSM_OFF_ACTIVE_STATE  12'h030
`define DCSM_OFF_IRQ_STATUS    12'h040
`define DCSM_OFF_IRQ_MASK      12'h044
`define DCSM_ACT_COUNT_LSB     16
`define DCSM_ACT_BUSY_BIT      15
`define DCSM_ACT_ID_LSB        8
`define DCSM_RESET_WORD        32'h0000_0000
`define DCSM_TRIG_BLOCK        2'h0
`define DCSM_TRIG_RESERVED     2'h1
`define DCSM_TRIG_BEAT         2'h2
`define DCSM_TRIG_TRANSACTION  2'h3
`endif

/* design/dcsm_pkg.sv */
// Types shared by the channel status monitor
package dcsm_pkg;
	// Per-channel interrupt source flags
	typedef struct packed {
		logic suspend_flag;
		logic transfer_complete_flag;
		logic transfer_error_flag;
	} dcsm_irq_src_t;
	// Active channel view
	typedef struct packed {
		logic [15:0] active_block_count;
		logic        active_busy_flag;
		logic [4:0]  id;
		logic [3:0]  level_request_executing;
	} dcsm_active_t;
	// Monitor events, one bit each in status and mask
	typedef enum logic [1:0] {
		DCSM_EV_BUSY_START = 2'h0,
		DCSM_EV_BUS_ERROR  = 2'h1,
		DCSM_EV_GRANT      = 2'h2,
		DCSM_EV_WB_DONE    = 2'h3
	} dcsm_event_t;
endpackage

/* design/dcsm_monitor.sv */
// Channel status monitor: summary vectors, active channel view, APB slave
// ============================================================
// Notes on behaviour
// - Summary bit set while channel interrupt pending
// - Summary bit drops when sources disabled/cleared
// - Busy bit set when channel starts transfer
// - Busy clears on completion, bus error, disable
// - Pending bit set while request waits
// - Pending clears on trigger start, error, disable
// - Block count shown in bits 31:16
// - Grant writes active count back to memory while active busy set
// - Count valid only while active busy set
// - Busy flag set on descriptor count read
// - Busy flag clears on count write-back
// - Channel index in bits 12:8, per grant
// - Level bit set while level request live
// - Trigger action selects triggers per transfer
// - Suspend, complete, error flags form interrupt
`timescale 1ns/1ps
`default_nettype none
`include "dcsm_defines.svh"

module dcsm_monitor
	import dcsm_pkg::*;
#(
	parameter int NCH = 12 // Channel count
) (
	input  wire logic                MCLK_IN,      // Controller clock, 200 MHz
	input  wire logic                NRST_IN,      // Asynchronous reset, active low
	// APB slave
	input  wire logic                PSEL_IN,      // Slave select
	input  wire logic                PENABLE_IN,   // Access phase
	input  wire logic                PWRITE_IN,    // Write direction
	input  wire logic [11:0]         PADDR_IN,     // Byte address
	input  wire logic [31:0]         PWDATA_IN,    // Write data
	output logic      [31:0]         PRDATA_OUT,   // Read data
	output logic                     PREADY_OUT,   // Transfer done
	output logic                     PSLVERR_OUT,  // Unmapped access
	// Controller side, same clock
	input  wire dcsm_irq_src_t [NCH-1:0] IRQ_FLAGS_IN,  // Per-channel interrupt flags
	input  wire dcsm_irq_src_t [NCH-1:0] IRQ_ENABLE_IN, // Per-channel interrupt enables
	input  wire logic [NCH-1:0]      CH_ENABLE_IN,     // Channel enabled
	input  wire logic [NCH-1:0]      CH_START_IN,      // Channel starts a transfer
	input  wire logic [NCH-1:0]      CH_BEAT_DONE_IN,  // Beat finished
	input  wire logic [NCH-1:0]      CH_TXN_DONE_IN,   // Transaction finished
	input  wire logic [NCH-1:0]      CH_BLOCK_DONE_IN, // Block finished
	input  wire logic [NCH-1:0]      CH_BUS_ERR_IN,    // Bus error seen
	input  wire logic [NCH-1:0]      CH_REQ_IN,        // Trigger request arrives
	input  wire logic [NCH-1:0]      CH_EXEC_IN,       // Trigger action starts
	input  wire logic [2*NCH-1:0]    CH_TRIGGER_ACTION_SELECT_IN,    // trigger_action_select per channel
	input  wire logic [2*NCH-1:0]    CH_LEVEL_IN,      // Priority level per channel
	input  wire logic                GRANT_IN,         // Arbiter grants new channel
	input  wire logic [4:0]          GRANT_ID_IN,      // Granted channel
	input  wire logic                WB_READ_IN,       // Count read from write-back memory
	input  wire logic [15:0]         WB_RDATA_IN,      // Count read
	input  wire logic                WB_WRITE_DONE_IN, // Write-back finished
	input  wire logic                COUNT_DEC_IN,     // Active count decrement
	output logic                     WB_WRITE_OUT,     // Write-back request pulse
	output logic [4:0]               WB_ID_OUT,        // Channel entry to write
	output logic [15:0]              WB_WDATA_OUT,     // Count to write
	output logic                     IRQ_OUT           // Level interrupt
);

	// ============================================================
	// Helpers
	// Transfer-done strobe for a trigger action code
	function automatic logic trig_done(input logic [1:0] act, input logic beat,
		input logic txn, input logic blk);
		unique case (act)
			`DCSM_TRIG_BLOCK:       trig_done = blk;
			`DCSM_TRIG_BEAT:        trig_done = beat;
			`DCSM_TRIG_TRANSACTION: trig_done = txn;
			default:                trig_done = 1'b0;      // Reserved code never completes
		endcase
	endfunction

	// ============================================================
	// State
	logic [NCH-1:0] irq_summary_r;   // Interrupt summary vector
	logic [NCH-1:0] busy_vec_r;      // Busy-channel vector
	logic [NCH-1:0] pend_vec_r;      // Pending-channel vector
	dcsm_active_t   active_r;        // Active channel view
	logic [3:0]     ev_status_r;     // Sticky event bits
	logic [3:0]     ev_mask_r;       // Event mask
	logic [3:0]     ev_set;          // Events this cycle
	logic [NCH-1:0] busy_clr;        // Busy clear terms
	logic [3:0]     lvl_live;        // Per-level activity
	logic           apb_acc;         // Access phase
	logic           rd_status;       // Status register read

	assign apb_acc   = PSEL_IN & PENABLE_IN;
	assign rd_status = apb_acc & ~PWRITE_IN & (PADDR_IN == `DCSM_OFF_IRQ_STATUS);

	// Busy clear: completed trigger action, error or disable
	always_comb begin
		for (int n = 0; n < NCH; n++) begin
			busy_clr[n] = trig_done(CH_TRIGGER_ACTION_SELECT_IN[2*n +: 2], CH_BEAT_DONE_IN[n],
				CH_TXN_DONE_IN[n], CH_BLOCK_DONE_IN[n]) | CH_BUS_ERR_IN[n]
				| ~CH_ENABLE_IN[n];
		end
	end

	// ============================================================
	// Interrupt summary: registered OR of enabled sources
	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			irq_summary_r <= '0;
		end else begin
			for (int n = 0; n < NCH; n++) begin
				// Drops once all sources disabled or cleared
				irq_summary_r[n] <= |(IRQ_FLAGS_IN[n] & IRQ_ENABLE_IN[n]);
			end
		end
	end

	// ============================================================
	// Busy vector: start on an enabled channel sets, clear terms win only without one
	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			busy_vec_r <= '0;
		end else begin
			for (int n = 0; n < NCH; n++) begin
				if (CH_START_IN[n] && CH_ENABLE_IN[n]) begin
					busy_vec_r[n] <= 1'b1;
				end else if (busy_clr[n]) begin
					busy_vec_r[n] <= 1'b0;
				end
			end
		end
	end

	// ============================================================
	// Pending vector: request sets, trigger start clears
	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			pend_vec_r <= '0;
		end else begin
			for (int n = 0; n < NCH; n++) begin
				// Error or disable abandons the request outright
				if (CH_BUS_ERR_IN[n] || !CH_ENABLE_IN[n]) begin
					pend_vec_r[n] <= 1'b0;
				end else if (CH_REQ_IN[n]) begin
					// Request beats a trigger start: the fresh request still waits
					pend_vec_r[n] <= 1'b1;
				end else if (CH_EXEC_IN[n]) begin
					pend_vec_r[n] <= 1'b0;
				end
			end
		end
	end

	// ============================================================
	// Level activity from busy and pending channels
	always_comb begin
		lvl_live = 4'h0;
		for (int n = 0; n < NCH; n++) begin
			if (busy_vec_r[n] || pend_vec_r[n]) begin
				lvl_live[CH_LEVEL_IN[2*n +: 2]] = 1'b1;
			end
		end
	end

	// ============================================================
	// Active channel registers
	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			active_r <= '0;
		end else begin
			active_r.level_request_executing <= lvl_live;
			if (GRANT_IN) begin
				active_r.id <= GRANT_ID_IN;
			end
			if (WB_READ_IN) begin
				active_r.active_block_count <= WB_RDATA_IN;
				active_r.active_busy_flag   <= 1'b1;
			end else if (WB_WRITE_DONE_IN) begin
				active_r.active_busy_flag   <= 1'b0;
			end else if (COUNT_DEC_IN && active_r.active_busy_flag) begin
				active_r.active_block_count <= active_r.active_block_count - 16'h0001;
			end
		end
	end

	// ============================================================
	// Write-back of the active count on a new grant
	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			WB_WRITE_OUT <= 1'b0;
			WB_ID_OUT    <= 5'h00;
			WB_WDATA_OUT <= 16'h0000;
		end else begin
			// Only a live count is worth saving
			WB_WRITE_OUT <= GRANT_IN & active_r.active_busy_flag;
			// Old index and count go out; the active view already takes the new grant
			if (GRANT_IN) begin
				WB_ID_OUT    <= active_r.id;
				WB_WDATA_OUT <= active_r.active_block_count;
			end
		end
	end

	// ============================================================
	// Event status: set wins over read-clear
	// Event strobes, each bit placed by its event code
	always_comb begin
		ev_set                     = 4'h0;
		ev_set[DCSM_EV_BUSY_START] = |CH_START_IN;
		ev_set[DCSM_EV_BUS_ERROR]  = |CH_BUS_ERR_IN;
		ev_set[DCSM_EV_GRANT]      = GRANT_IN;
		ev_set[DCSM_EV_WB_DONE]    = WB_WRITE_DONE_IN;
	end
	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			ev_status_r <= 4'h0;
		end else begin
			ev_status_r <= (rd_status ? 4'h0 : ev_status_r) | ev_set;
		end
	end

	// Mask register and interrupt output
	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			ev_mask_r <= 4'h0;
			IRQ_OUT   <= 1'b0;
		end else begin
			if (apb_acc && PWRITE_IN && PADDR_IN == `DCSM_OFF_IRQ_MASK) begin
				ev_mask_r <= PWDATA_IN[3:0];
			end
			// Line follows the status word as it stands after this edge;
			// a mask write takes hold one cycle later
			IRQ_OUT <= |((rd_status ? 4'h0 : ev_status_r) | ev_set) & (|ev_mask_r) &
				|(((rd_status ? 4'h0 : ev_status_r) | ev_set) & ev_mask_r);
		end
	end

	// ============================================================
	// APB: setup cycle then one-cycle access; answer registered
	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			PRDATA_OUT  <= `DCSM_RESET_WORD;
			PREADY_OUT  <= 1'b0;
			PSLVERR_OUT <= 1'b0;
		end else begin
			// Zero wait states: the answer is decoded at the setup edge
			// and stands for the single access cycle that follows
			PREADY_OUT  <= PSEL_IN & ~PENABLE_IN; // Ready in access phase
			PSLVERR_OUT <= 1'b0;
			PRDATA_OUT  <= `DCSM_RESET_WORD;
			if (PSEL_IN && !PENABLE_IN) begin
				unique case (PADDR_IN)
					// Status words ignore writes; unused bits zero
					`DCSM_OFF_IRQ_SUMMARY:  PRDATA_OUT <= 32'(irq_summary_r);
					`DCSM_OFF_BUSY_VECTOR:  PRDATA_OUT <= 32'(busy_vec_r);
					`DCSM_OFF_PEND_VECTOR:  PRDATA_OUT <= 32'(pend_vec_r);
					`DCSM_OFF_ACTIVE_STATE: PRDATA_OUT <= {active_r.active_block_count,
						active_r.active_busy_flag, 2'h0, active_r.id, 4'h0,
						active_r.level_request_executing};
					`DCSM_OFF_IRQ_STATUS:   PRDATA_OUT <= {28'h0000000, ev_status_r | ev_set};
					`DCSM_OFF_IRQ_MASK:     PRDATA_OUT <= {28'h0000000, ev_mask_r};
					default:                PSLVERR_OUT <= 1'b1; // Unmapped
				endcase
			end
		end
	end

	// ============================================================
	// Checks
	// Every channel gets its own copy, so a scenario on any channel
	// reaches them; a channel 0 only check would sleep through most runs
	for (genvar g = 0; g < NCH; g++) begin : g_chan_chk
		// Start on an enabled channel marks it busy
		busy_start_a: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
			CH_START_IN[g] && CH_ENABLE_IN[g] |=> busy_vec_r[g])
			else $error("busy not set");
		// Disable without a start drops busy
		busy_clear_a: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
			!CH_ENABLE_IN[g] && !CH_START_IN[g] |=> !busy_vec_r[g])
			else $error("busy not cleared");
		// Bus error without a start drops busy
		busy_error_a: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
			CH_BUS_ERR_IN[g] && !CH_START_IN[g] |=> !busy_vec_r[g])
			else $error("busy kept on error");
		// Request on a healthy channel marks it pending
		pend_set_a: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
			CH_REQ_IN[g] && CH_ENABLE_IN[g] && !CH_BUS_ERR_IN[g] |=> pend_vec_r[g])
			else $error("pend lost");
		// Bus error abandons the request
		pend_error_a: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
			CH_BUS_ERR_IN[g] |=> !pend_vec_r[g])
			else $error("pend kept on error");
		// Trigger start with no new request clears pending
		pend_exec_a: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
			CH_EXEC_IN[g] && !CH_REQ_IN[g] |=> !pend_vec_r[g])
			else $error("pend kept on trigger start");
		// Any enabled source raises the summary bit
		irq_summary_a: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
			(|(IRQ_FLAGS_IN[g] & IRQ_ENABLE_IN[g])) |=> irq_summary_r[g])
			else $error("summary not set");
		// No enabled source left, the summary bit drops
		irq_drop_a: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
			!(|(IRQ_FLAGS_IN[g] & IRQ_ENABLE_IN[g])) |=> !irq_summary_r[g])
			else $error("summary not cleared");
		// A live channel lights the bit of its level
		level_live_a: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
			busy_vec_r[g] || pend_vec_r[g] |=>
			active_r.level_request_executing[$past(CH_LEVEL_IN[2*g +: 2])])
			else $error("level bit missing");
	end

	// Quiet channels leave every level bit clear
	level_idle_a: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
		busy_vec_r == '0 && pend_vec_r == '0 |=> active_r.level_request_executing == 4'h0)
		else $error("level bit stuck");
	// Bits above the channels read as zero
	read_zero_a: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
		PSEL_IN && !PENABLE_IN && PADDR_IN == `DCSM_OFF_BUSY_VECTOR |=> PRDATA_OUT[31:NCH] == '0)
		else $error("unused bits not zero");

	// Active channel: count read, decrement, write-back done
	active_busy_flag_set_a: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
		WB_READ_IN |=> active_r.active_busy_flag)
		else $error("active_busy_flag not set");
	// Count loaded together with the flag
	active_count_a: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
		WB_READ_IN |=> active_r.active_block_count == $past(WB_RDATA_IN))
		else $error("count not loaded");
	// One unit less in flight on a decrement
	count_dec_a: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
		COUNT_DEC_IN && active_r.active_busy_flag && !WB_READ_IN && !WB_WRITE_DONE_IN |=>
		active_r.active_block_count == $past(active_r.active_block_count) - 16'h0001)
		else $error("count not decremented");
	// Write-back done drops the flag
	active_busy_flag_clr_a: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
		WB_WRITE_DONE_IN && !WB_READ_IN |=> !active_r.active_busy_flag)
		else $error("active_busy_flag held");
	// Grant loads the new index
	grant_id_a: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
		GRANT_IN |=> active_r.id == $past(GRANT_ID_IN))
		else $error("id stale");

	// Write-back steps: grant with a live count, then the saved entry
	sequence grant_live_s;
		GRANT_IN && active_r.active_busy_flag;
	endsequence
	sequence wb_pulse_s;
		WB_WRITE_OUT && WB_ID_OUT == $past(active_r.id)
		&& WB_WDATA_OUT == $past(active_r.active_block_count);
	endsequence
	wb_grant_a: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
		grant_live_s |=> wb_pulse_s)
		else $error("no write-back");
	// No grant or an idle count, nothing written
	wb_idle_a: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
		!(GRANT_IN && active_r.active_busy_flag) |=> !WB_WRITE_OUT)
		else $error("stray write-back");

	// Event status and interrupt line
	ev_grant_a: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
		GRANT_IN |=> ev_status_r[DCSM_EV_GRANT])
		else $error("grant event lost");
	// Unmasked event drives the line while the mask is steady
	irq_level_a: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
		(|(ev_status_r & ev_mask_r)) && $stable(ev_mask_r) |-> IRQ_OUT)
		else $error("interrupt line low");
	irq_quiet_a: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
		!(|(ev_status_r & ev_mask_r)) && $stable(ev_mask_r) |-> !IRQ_OUT)
		else $error("interrupt line high");

	// Bus answers: one ready per setup, never two in a row
	apb_ready_a: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
		PSEL_IN && !PENABLE_IN |=> PREADY_OUT)
		else $error("ready missing");
	ready_once_a: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
		PREADY_OUT |=> !PREADY_OUT)
		else $error("ready held");

endmodule // dcsm_monitor
`default_nettype wire

/* tb/dcsm_monitor_tb.sv */
// Self-checking bench for the channel status monitor
`timescale 1ns/1ps
`default_nettype none
`include "dcsm_defines.svh"
module dcsm_monitor_tb
	import dcsm_pkg::*;
;
	// ============================================================
	// Signals
	localparam logic [11:0] SUM = `DCSM_OFF_IRQ_SUMMARY;
	localparam logic [11:0] BSY = `DCSM_OFF_BUSY_VECTOR;
	localparam logic [11:0] PND = `DCSM_OFF_PEND_VECTOR;
	localparam logic [11:0] ACT = `DCSM_OFF_ACTIVE_STATE;
	localparam logic [11:0] STA = `DCSM_OFF_IRQ_STATUS;
	localparam logic [11:0] MSK = `DCSM_OFF_IRQ_MASK;
	logic                clk, nrst, psel, penable, pwrite, pready, pslverr, er;
	logic [11:0]         paddr;
	logic [31:0]         pwdata, prdata, rd;
	dcsm_irq_src_t [11:0] flg, ena;   // Interrupt sources and enables
	logic [11:0]         en, start, beat, txn, blk, berr, req, exec;
	logic [23:0]         trig, lvl;
	logic                grant, wbrd, wbdone, cdec, wbwr, irq;
	logic [4:0]          gid, wbid;
	logic [15:0]         wbdata, wbwd;
	logic [1:0]          code;
	int                  fail_count, check_count, n;
	dcsm_monitor dcsm_monitor_i (.MCLK_IN(clk), .NRST_IN(nrst), .PSEL_IN(psel), .PENABLE_IN(penable),
		.PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
		.PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .IRQ_FLAGS_IN(flg), .IRQ_ENABLE_IN(ena),
		.CH_ENABLE_IN(en), .CH_START_IN(start), .CH_BEAT_DONE_IN(beat), .CH_TXN_DONE_IN(txn),
		.CH_BLOCK_DONE_IN(blk), .CH_BUS_ERR_IN(berr), .CH_REQ_IN(req), .CH_EXEC_IN(exec),
		.CH_TRIGGER_ACTION_SELECT_IN(trig), .CH_LEVEL_IN(lvl), .GRANT_IN(grant), .GRANT_ID_IN(gid),
		.WB_READ_IN(wbrd), .WB_RDATA_IN(wbdata), .WB_WRITE_DONE_IN(wbdone), .COUNT_DEC_IN(cdec),
		.WB_WRITE_OUT(wbwr), .WB_ID_OUT(wbid), .WB_WDATA_OUT(wbwd), .IRQ_OUT(irq));
	// ============================================================
	// Clock, 5 ns period
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// ============================================================
	// Tasks
	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One APB transfer; request held until pready seen high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int k;
		@(posedge clk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 16) begin
			fail_count++;
			summarize();
		end
	endtask
	// Two idle edges first so registered views settle
	task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		repeat (2) @(posedge clk);
		apb(1'b0, a, 32'h0);
		chk(rd & m, e);
	endtask
	// One-cycle pulse on a controller event vector
	task automatic pulse(input int k, input logic [11:0] v);
		@(posedge clk);
		case (k)
			0: start <= v;
			1: blk <= v;
			2: beat <= v;
			3: txn <= v;
			4: berr <= v;
			5: req <= v;
			default: exec <= v;
		endcase
		@(posedge clk);
		{start, blk, beat, txn, berr, req, exec} <= '0;
	endtask
	// ============================================================
	// Main sequence
	initial begin
		{nrst, psel, penable, pwrite, paddr, pwdata, flg, start, beat, txn, blk, berr, req, exec} = '0;
		{trig, lvl, grant, wbrd, wbdone, cdec, gid, wbdata} = '0;
		ena = '1;
		en = '1;
		fail_count = 0;
		check_count = 0;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		for (int a = 'h24; a <= 'h30; a += 4) rdchk(a[11:0], '1, 32'h0);
		rdchk(MSK, '1, 32'h0);
		apb(1'b1, BSY, 32'hffffffff);
		rdchk(BSY, '1, 32'h0);
		apb(1'b0, 12'h050, 32'h0);
		chk({31'h0, er}, 32'h1);
		$display("test registers finished");
		// Each source alone raises the summary bit
		for (int i = 0; i < 3; i++) begin
			flg[3] <= dcsm_irq_src_t'(3'b001 << i);
			rdchk(SUM, '1, 32'h8);
		end
		ena[3] <= '0;
		rdchk(SUM, '1, 32'h0);
		ena[3] <= '1;
		rdchk(SUM, '1, 32'h8);
		flg[3] <= '0;
		rdchk(SUM, '1, 32'h0);
		$display("test summary finished");
		// Reserved code last: its busy bit never completes
		for (int i = 0; i < 4; i++) begin
			code = (i == 3) ? 2'h1 : 2'(i + (i > 0));
			trig[11:10] <= code;
			pulse(0, 12'h020);
			rdchk(BSY, '1, 32'h20);
			pulse((code < 2'h2) ? 1 : int'(code), 12'h020);
			rdchk(BSY, '1, (code == 2'h1) ? 32'h20 : 32'h0);
		end
		en[5] <= 1'b0;
		rdchk(BSY, '1, 32'h0);
		en[5] <= 1'b1;
		$display("test busy finished");
		lvl[5:4] <= 2'h2;
		pulse(5, 12'h004);
		rdchk(PND, '1, 32'h4);
		rdchk(ACT, 32'hf, 32'h4);
		pulse(6, 12'h004);
		rdchk(PND, '1, 32'h0);
		rdchk(ACT, 32'hf, 32'h0);
		pulse(5, 12'h004);
		pulse(0, 12'h040);
		pulse(4, 12'h044);
		rdchk(PND, '1, 32'h0);
		rdchk(BSY, '1, 32'h0);
		pulse(5, 12'h004);
		en[2] <= 1'b0;
		rdchk(PND, '1, 32'h0);
		en[2] <= 1'b1;
		$display("test pending finished");
		// Start and bus error events already logged
		apb(1'b1, MSK, 32'h4);
		rdchk(MSK, '1, 32'h4);
		rdchk(STA, '1, 32'h3);
		@(posedge clk) {grant, gid} <= {1'b1, 5'd9};
		@(posedge clk) {grant, wbrd, wbdata} <= {1'b0, 1'b1, 16'h1234};
		@(posedge clk) {wbrd, cdec} <= 2'b01;
		@(posedge clk) cdec <= 1'b0;
		rdchk(ACT, '1, 32'h12338900);
		chk({31'h0, irq}, 32'h1);
		@(posedge clk) {grant, gid} <= {1'b1, 5'd4};
		@(posedge clk) grant <= 1'b0;
		for (n = 0; n < 8 && wbwr !== 1'b1; n++) @(posedge clk);
		if (n == 8) begin
			fail_count++;
			summarize();
		end
		chk({11'h0, wbid, wbwd}, {11'h0, 5'd9, 16'h1233});
		@(posedge clk) wbdone <= 1'b1;
		@(posedge clk) wbdone <= 1'b0;
		rdchk(ACT, 32'hff00, 32'h0400);
		rdchk(STA, '1, 32'hc);
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		rdchk(STA, '1, 32'h0);
		$display("test active finished");
		@(posedge clk) nrst <= 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		rdchk(ACT, '1, 32'h0);
		$display("test second reset finished");
		summarize();
	end
endmodule // dcsm_monitor_tb
`default_nettype wire
